// ---- include/cli_pkg.sv ----
/*
  Package for the CAN interface status indicator block: AXI4-Lite
  register map, field positions, reset values, prescaler defaults.
  Assumes a 32-bit AXI4-Lite register bus and a single clock.
*/
package cli_pkg;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] REG_CTRL_OFF = 8'h00;     // device state control
  localparam logic [7:0] REG_FLASH_OFF = 8'h04;    // flash width prescaler
  localparam logic [7:0] REG_SLOW_OFF = 8'h08;     // slow half period
  localparam logic [7:0] REG_FAST_OFF = 8'h0C;     // fast half period
  localparam logic [7:0] REG_OVR_EN_OFF = 8'h10;   // override enables
  localparam logic [7:0] REG_OVR_VAL_OFF = 8'h14;  // override pattern
  localparam logic [7:0] REG_STATUS_OFF = 8'h18;   // live indicator state

  // ************************************************************
  // control register fields
  // ************************************************************
  localparam int CTRL_CONFIGURED_BIT = 0;  // usb configured by host
  localparam int CTRL_FW_FAULT_BIT = 1;    // firmware config fault
  localparam int CTRL_PWR_FAULT_BIT = 2;   // insufficient supply
  localparam int CTRL_UPDATE_BIT = 3;      // firmware update running
  localparam int CTRL_RUNNING_BIT = 4;     // running sequence test

  // ************************************************************
  // reset values and timing counts (cycles of the 250 MHz clock)
  // ************************************************************
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CLK_MHZ = 250;
  localparam int FLASH_US = 20000;   // flash pulse width, us
  localparam int SLOW_MS = 500;      // slow half period, ms
  localparam int FAST_MS = 125;      // fast half period, ms
  localparam logic [31:0] FLASH_RST = 32'(FLASH_US * CLK_MHZ);
  localparam logic [31:0] SLOW_RST = 32'(SLOW_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] FAST_RST = 32'(FAST_MS * 1000 * CLK_MHZ);

  // ************************************************************
  // axi response codes
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // per-channel event carrier from a CAN controller
  typedef struct packed {
    logic frame;       // frame sent or received, one pulse
    logic err_frame;   // error frame received, one pulse
    logic err_passive; // error passive level
    logic overrun;     // receive overrun, one pulse
    logic bus_off;     // bus off level
  } cli_chan_type;

  // one dual-colour indicator drive
  typedef struct packed {
    logic col_a;  // green on power, yellow on traffic
    logic col_b;  // yellow on power, red on traffic
  } cli_led_type;

endpackage : cli_pkg

// ---- sim/can_interface_led_status_test.sv ----
/*
  Self-checking bench for the indicator block: registers over
  AXI4-Lite, controller events driven per channel, colours observed.
  Assumes cli_pkg, cli_led_status and cli_led_watch are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module can_interface_led_status_test;
  logic clk, rst, hold;
  cli_pkg::cli_chan_type [3:0] chan;
  cli_pkg::cli_led_type power_indicator;
  cli_pkg::cli_led_type [3:0] trf;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb;
  logic [9:0][15:0] cnt;
  logic [15:0] multi;
  int failures, checks_done;

  cli_led_status #(.NCH(4)) cli_led_status_inst (
    .mclk_in(clk), .rst_in(rst), .chan_in(chan),
    .power_indicator_out(power_indicator), .traffic_out(trf),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  cli_led_watch #(.NCH(4)) cli_led_watch_inst (
    .clk_in(clk), .hold_in(hold), .power_in(power_indicator), .traffic_in(trf),
    .on_cnt_out(cnt), .multi_out(multi));

  // clock, 4 ns period
  always #2 clk = ~clk;

  // ************************************************************
  // helpers
  // ************************************************************
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ap, wp;
    @(posedge clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    ap = 1; wp = 1;
    while (ap || wp) begin
      @(posedge clk);
      if (ap && awready === 1'b1) begin ap = 0; awvalid <= 1'b0; end
      if (wp && wready === 1'b1) begin wp = 0; wvalid <= 1'b0; end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    chk("bresp", 32'(er), 32'(bresp));
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    chk("rdata", ed, rdata);
    chk("rresp", 32'(er), 32'(rresp));
    rready <= 1'b0;
  endtask : rd

  // window of counting: open zeroes the counts, close samples len cycles
  task win_open();
    repeat (3) @(posedge clk);
    hold <= 1'b1;
    @(posedge clk) hold <= 1'b0;
  endtask : win_open

  task win_close(input int len);
    repeat (len + 1) @(posedge clk);
  endtask : win_close

  task pulse(input int c, input int f);
    @(posedge clk);
    case (f)
      0: chan[c].frame <= 1'b1;
      1: chan[c].err_frame <= 1'b1;
      2: chan[c].overrun <= 1'b1;
      default: chan[c].bus_off <= 1'b1;
    endcase
    @(posedge clk);
    chan[c].frame <= 1'b0; chan[c].err_frame <= 1'b0;
    chan[c].overrun <= 1'b0; chan[c].bus_off <= 1'b0;
  endtask : pulse

  // device state written, all channels expected alike; pg < 0 skips green
  task mode(input logic [31:0] ctrl, input int len, input int pg, input int py,
            input int ty, input int tr);
    wr(cli_pkg::REG_CTRL_OFF, ctrl, cli_pkg::RESP_OKAY);
    win_open();
    win_close(len);
    if (pg >= 0) chk("power green", 32'(pg), 32'(cnt[0]));
    chk("power yellow", 32'(py), 32'(cnt[1]));
    for (int c = 0; c < 4; c++) begin
      chk("traffic yellow", 32'(ty), 32'(cnt[2+2*c]));
      chk("traffic red", 32'(tr), 32'(cnt[3+2*c]));
    end
  endtask : mode

  task print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    clk = 0; rst = 1; hold = 1; chan = '0;
    awaddr = 8'h00; awvalid = 0; wdata = 32'h0; wvalid = 0; bready = 0;
    araddr = 8'h00; arvalid = 0; rready = 0;
    wstrb = 4'hF;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(cli_pkg::REG_CTRL_OFF, cli_pkg::CTRL_RST, cli_pkg::RESP_OKAY);
    rd(cli_pkg::REG_FLASH_OFF, cli_pkg::FLASH_RST, cli_pkg::RESP_OKAY);
    rd(cli_pkg::REG_SLOW_OFF, cli_pkg::SLOW_RST, cli_pkg::RESP_OKAY);
    rd(cli_pkg::REG_FAST_OFF, cli_pkg::FAST_RST, cli_pkg::RESP_OKAY);
    rd(cli_pkg::REG_OVR_EN_OFF, 32'h0, cli_pkg::RESP_OKAY);
    wr(cli_pkg::REG_FLASH_OFF, 32'h4, cli_pkg::RESP_OKAY);
    wr(cli_pkg::REG_SLOW_OFF, 32'h8, cli_pkg::RESP_OKAY);
    wr(cli_pkg::REG_FAST_OFF, 32'h2, cli_pkg::RESP_OKAY);
    // low byte lane only: upper bytes must keep their zeros
    wstrb <= 4'h1;
    wr(cli_pkg::REG_FAST_OFF, 32'hA5A5_A502, cli_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    rd(cli_pkg::REG_FAST_OFF, 32'h2, cli_pkg::RESP_OKAY);
    wr(cli_pkg::REG_STATUS_OFF, 32'hFF, cli_pkg::RESP_SLVERR);
    rd(8'h1C, 32'h0, cli_pkg::RESP_SLVERR);
    mode(32'h0, 32, 0, 16, 0, 0);
    mode(32'h3, 32, 16, 16, 16, 16);
    mode(32'h5, 32, 16, 16, 16, 0);
    mode(32'h9, 32, -1, 0, 16, 0);
    mode(32'h11, 80, 8, 8, 8, 8);
    chk("one lit", 32'h0, 32'(multi));
    mode(32'h1, 32, 32, 0, 0, 0);
    // channel events while configured
    win_open();
    pulse(0, 0);
    win_close(30);
    chk("flash yellow", 32'h4, 32'(cnt[2]));
    chk("flash no red", 32'h0, 32'(cnt[3]));
    chk("other idle", 32'h0, 32'(cnt[4]));
    win_open();
    pulse(3, 1);
    win_close(30);
    chk("flash red", 32'h4, 32'(cnt[9]));
    chk("flash no yellow", 32'h0, 32'(cnt[8]));
    @(posedge clk) chan[2].err_passive <= 1'b1;
    win_open();
    win_close(32);
    chk("passive red", 32'd16, 32'(cnt[7]));
    @(posedge clk) chan[2].err_passive <= 1'b0;
    pulse(3, 2);
    win_open();
    win_close(32);
    chk("overrun red", 32'd32, 32'(cnt[9]));
    pulse(3, 3);
    win_open();
    win_close(32);
    chk("bus off clears", 32'h0, 32'(cnt[9]));
    wr(cli_pkg::REG_OVR_VAL_OFF, 32'h1, cli_pkg::RESP_OKAY);
    wr(cli_pkg::REG_OVR_EN_OFF, 32'h1, cli_pkg::RESP_OKAY);
    mode(32'h1, 32, 0, 32, 0, 0);
    print_verdict();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule : can_interface_led_status_test

`default_nettype wire

// ---- sim/cli_led_watch.sv ----
/*
  Observer standing in for the user who watches the indicators: counts
  the cycles each colour is lit while hold is low.
  Assumes the indicator drives are registered levels on one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module cli_led_watch #(
  parameter int NCH = 4
) (
  input wire logic clk_in,                             // system clock
  input wire logic hold_in,                            // high zeroes counts
  input wire cli_pkg::cli_led_type power_in,           // power drive
  input wire cli_pkg::cli_led_type [NCH-1:0] traffic_in, // traffic drives
  output var logic [2*NCH+1:0][15:0] on_cnt_out,       // lit cycles per colour
  output var logic [15:0] multi_out                    // cycles with two lit
);
  logic [2*NCH+1:0] lit;

  // one bit per colour: power g,y then traffic y,r per channel
  always_comb begin
    lit[0] = power_in.col_a;
    lit[1] = power_in.col_b;
    for (int c = 0; c < NCH; c++) begin
      lit[2+2*c] = traffic_in[c].col_a;
      lit[3+2*c] = traffic_in[c].col_b;
    end
  end

  // lit-time accumulation
  always_ff @(posedge clk_in) begin
    for (int k = 0; k < 2*NCH+2; k++) begin
      on_cnt_out[k] <= hold_in ? 16'h0 : on_cnt_out[k] + 16'(lit[k]);
    end
    multi_out <= hold_in ? 16'h0 : multi_out + 16'($countones(lit) > 1);
  end
endmodule : cli_led_watch

`default_nettype wire

// ---- verilog/cli_led_status.sv ----
/*
  Status indicator logic for a multi-channel CAN interface: one power
  indicator and one traffic indicator per channel, with registers on
  AXI4-Lite. Assumes event pulses and levels from CAN controllers on
  the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module cli_led_status #(
  parameter int NCH = 4
) (
  input wire logic mclk_in,                          // 250 MHz clock
  input wire logic rst_in,                           // sync reset, high
  input wire cli_pkg::cli_chan_type [NCH-1:0] chan_in, // controller status
  output var cli_pkg::cli_led_type power_indicator_out, // power led drive
  output var cli_pkg::cli_led_type [NCH-1:0] traffic_out, // traffic led drive
  input wire logic [7:0] s_axi_awaddr,               // write address
  input wire logic s_axi_awvalid,                    // write addr valid
  output logic s_axi_awready,                        // write addr ready
  input wire logic [31:0] s_axi_wdata,               // write data
  input wire logic [3:0] s_axi_wstrb,                // write strobes
  input wire logic s_axi_wvalid,                     // write data valid
  output logic s_axi_wready,                         // write data ready
  output logic [1:0] s_axi_bresp,                    // write response
  output logic s_axi_bvalid,                         // write resp valid
  input wire logic s_axi_bready,                     // write resp ready
  input wire logic [7:0] s_axi_araddr,               // read address
  input wire logic s_axi_arvalid,                    // read addr valid
  output logic s_axi_arready,                        // read addr ready
  output logic [31:0] s_axi_rdata,                   // read data
  output logic [1:0] s_axi_rresp,                    // read response
  output logic s_axi_rvalid,                         // read data valid
  input wire logic s_axi_rready                      // read data ready
);

  localparam int NLED = NCH + 1;
  localparam int SEQ = 2 * NLED;

  // refuse channel counts the status word cannot hold
  if (NCH < 1 || NCH > 10) begin : g_chk
    $error("cli_led_status: NCH must be 1..10");
  end

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // ************************************************************
  // registers
  // ************************************************************
  logic [31:0] ctrl_q;
  logic [31:0] flash_q;
  logic [31:0] slow_q;
  logic [31:0] fast_q;
  logic [31:0] ovr_en_q;
  logic [31:0] ovr_val_q;
  logic [7:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  logic wr_go;
  logic wr_hit;

  // write channel capture, either order
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_hit = awaddr_q == cli_pkg::REG_CTRL_OFF || awaddr_q == cli_pkg::REG_FLASH_OFF ||
                  awaddr_q == cli_pkg::REG_SLOW_OFF || awaddr_q == cli_pkg::REG_FAST_OFF ||
                  awaddr_q == cli_pkg::REG_OVR_EN_OFF || awaddr_q == cli_pkg::REG_OVR_VAL_OFF;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? cli_pkg::RESP_OKAY : cli_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register storage
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ctrl_q <= cli_pkg::CTRL_RST;
      flash_q <= cli_pkg::FLASH_RST;
      slow_q <= cli_pkg::SLOW_RST;
      fast_q <= cli_pkg::FAST_RST;
      ovr_en_q <= 32'h0000_0000; // no override by default
      ovr_val_q <= 32'h0000_0000;
    end else if (wr_go) begin
      unique case (awaddr_q)
        cli_pkg::REG_CTRL_OFF: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
        cli_pkg::REG_FLASH_OFF: flash_q <= merge(flash_q, wdata_q, wstrb_q);
        cli_pkg::REG_SLOW_OFF: slow_q <= merge(slow_q, wdata_q, wstrb_q);
        cli_pkg::REG_FAST_OFF: fast_q <= merge(fast_q, wdata_q, wstrb_q);
        cli_pkg::REG_OVR_EN_OFF: ovr_en_q <= merge(ovr_en_q, wdata_q, wstrb_q);
        cli_pkg::REG_OVR_VAL_OFF: ovr_val_q <= merge(ovr_val_q, wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // ************************************************************
  // pattern timebase
  // ************************************************************
  logic [31:0] slow_cnt_q;
  logic [31:0] fast_cnt_q;
  logic slow_ph_q;
  logic fast_ph_q;
  logic slow_tick;
  logic [$clog2(SEQ)-1:0] run_idx_q;

  assign slow_tick = slow_cnt_q + 32'h1 >= slow_q;

  // slow and fast half-period dividers, equal on and off
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      slow_cnt_q <= 32'h0000_0000;
      fast_cnt_q <= 32'h0000_0000;
      slow_ph_q <= 1'b0;
      fast_ph_q <= 1'b0;
    end else begin
      if (slow_tick) begin
        slow_cnt_q <= 32'h0000_0000;
        slow_ph_q <= !slow_ph_q;
      end else begin
        slow_cnt_q <= slow_cnt_q + 32'h1;
      end
      if (fast_cnt_q + 32'h1 >= fast_q) begin
        fast_cnt_q <= 32'h0000_0000;
        fast_ph_q <= !fast_ph_q;
      end else begin
        fast_cnt_q <= fast_cnt_q + 32'h1;
      end
    end
  end

  // running step advances once per slow half period
  always_ff @(posedge mclk_in) begin
    if (rst_in || !ctrl_q[cli_pkg::CTRL_RUNNING_BIT]) begin
      run_idx_q <= '0;
    end else if (slow_tick) begin
      run_idx_q <= (run_idx_q == ($clog2(SEQ))'(SEQ - 1)) ? '0 : run_idx_q + 1'b1;
    end
  end

  // ************************************************************
  // per-channel event state
  // ************************************************************
  logic [NCH-1:0][31:0] yel_cnt_q;
  logic [NCH-1:0][31:0] red_cnt_q;
  logic [NCH-1:0] ovr_q;

  // flash stretchers, each new event restarts the pulse
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      yel_cnt_q <= '0;
      red_cnt_q <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (chan_in[c].frame) begin
          yel_cnt_q[c] <= flash_q;
        end else if (yel_cnt_q[c] != 32'h0) begin
          yel_cnt_q[c] <= yel_cnt_q[c] - 32'h1;
        end
        if (chan_in[c].err_frame) begin
          red_cnt_q[c] <= flash_q;
        end else if (red_cnt_q[c] != 32'h0) begin
          red_cnt_q[c] <= red_cnt_q[c] - 32'h1;
        end
      end
    end
  end

  // overrun latch, cleared only by bus off; a new overrun wins
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ovr_q <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (chan_in[c].overrun) begin
          ovr_q[c] <= 1'b1;
        end else if (chan_in[c].bus_off) begin
          ovr_q[c] <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // indicator pattern selection
  // ************************************************************
  cli_pkg::cli_led_type pwr_d;
  cli_pkg::cli_led_type [NCH-1:0] trf_d;

  // device state first, then per-channel priority
  always_comb begin
    pwr_d = '{col_a: 1'b1, col_b: 1'b0};
    trf_d = '0;
    if (ctrl_q[cli_pkg::CTRL_RUNNING_BIT]) begin
      pwr_d = '{col_a: run_idx_q == '0, col_b: run_idx_q == 1};
      for (int c = 0; c < NCH; c++) begin
        trf_d[c].col_a = int'(run_idx_q) == 2 * c + 2;
        trf_d[c].col_b = int'(run_idx_q) == 2 * c + 3;
      end
    end else if (ctrl_q[cli_pkg::CTRL_FW_FAULT_BIT]) begin
      pwr_d = '{col_a: !slow_ph_q, col_b: slow_ph_q};
      for (int c = 0; c < NCH; c++) begin
        trf_d[c] = '{col_a: !slow_ph_q, col_b: slow_ph_q};
      end
    end else if (ctrl_q[cli_pkg::CTRL_PWR_FAULT_BIT]) begin
      pwr_d = '{col_a: !slow_ph_q, col_b: slow_ph_q};
      for (int c = 0; c < NCH; c++) begin
        trf_d[c] = '{col_a: slow_ph_q, col_b: 1'b0};
      end
    end else if (!ctrl_q[cli_pkg::CTRL_CONFIGURED_BIT]) begin
      pwr_d = '{col_a: 1'b0, col_b: slow_ph_q};
    end else if (ctrl_q[cli_pkg::CTRL_UPDATE_BIT]) begin
      for (int c = 0; c < NCH; c++) begin
        trf_d[c] = '{col_a: fast_ph_q, col_b: 1'b0};
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        // red: overrun, then error passive, then error flash
        if (ovr_q[c]) begin
          trf_d[c].col_b = 1'b1;
        end else if (chan_in[c].err_passive) begin
          trf_d[c].col_b = fast_ph_q;
        end else begin
          trf_d[c].col_b = red_cnt_q[c] != 32'h0;
        end
        trf_d[c].col_a = yel_cnt_q[c] != 32'h0 && !trf_d[c].col_b;
      end
    end
    // program override per indicator, one enable bit and two value bits per indicator
    for (int i = 0; i < NLED; i++) begin
      if (ovr_en_q[i]) begin
        if (i == 0) begin
          pwr_d = ovr_val_q[2*i +: 2];
        end else begin
          trf_d[i-1] = ovr_val_q[2*i +: 2];
        end
      end
    end
  end

  // registered indicator drives
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      power_indicator_out <= '0;
      traffic_out <= '0;
    end else begin
      power_indicator_out <= pwr_d;
      traffic_out <= trf_d;
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  logic [31:0] rd_d;

  // read decode, status shows the live drives
  always_comb begin
    unique case (s_axi_araddr)
      cli_pkg::REG_CTRL_OFF: rd_d = ctrl_q;
      cli_pkg::REG_FLASH_OFF: rd_d = flash_q;
      cli_pkg::REG_SLOW_OFF: rd_d = slow_q;
      cli_pkg::REG_FAST_OFF: rd_d = fast_q;
      cli_pkg::REG_OVR_EN_OFF: rd_d = ovr_en_q;
      cli_pkg::REG_OVR_VAL_OFF: rd_d = ovr_val_q;
      cli_pkg::REG_STATUS_OFF: rd_d = 32'({ovr_q, traffic_out, power_indicator_out});
      default: rd_d = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // one read at a time, answered the cycle after address
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_d;
      s_axi_rresp <= (s_axi_araddr <= cli_pkg::REG_STATUS_OFF && s_axi_araddr[1:0] == 2'h0) ?
                     cli_pkg::RESP_OKAY : cli_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  chk_overrun_red: assert property (@(posedge mclk_in) disable iff (rst_in)
    ovr_q[NCH-1] && ctrl_q[4:0] == 5'h01 && !ovr_en_q[NCH] |=> traffic_out[NCH-1].col_b)
    else $error("overrun does not light red");
  chk_overrun_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
    ovr_q[NCH-1] && !chan_in[NCH-1].bus_off |=> ovr_q[NCH-1])
    else $error("overrun latch lost before bus off");
  chk_unconf_off: assert property (@(posedge mclk_in) disable iff (rst_in)
    ctrl_q[4:0] == 5'h00 && ovr_en_q == 32'h0 |=> traffic_out == '0 && !power_indicator_out.col_a)
    else $error("unconfigured pattern wrong");
  chk_healthy_green: assert property (@(posedge mclk_in) disable iff (rst_in)
    ctrl_q[4:0] == 5'h01 && !ovr_en_q[0] |=> power_indicator_out == 2'b10)
    else $error("power not steady green");
  chk_fw_waver: assert property (@(posedge mclk_in) disable iff (rst_in)
    ctrl_q[4:0] == 5'h03 && ovr_en_q == 32'h0 |=>
      traffic_out[0].col_a != traffic_out[0].col_b && traffic_out[0] == traffic_out[NCH-1])
    else $error("fault waver wrong");
  chk_frame_flash: assert property (@(posedge mclk_in) disable iff (rst_in)
    chan_in[0].frame && flash_q != 32'h0 |=> yel_cnt_q[0] == flash_q)
    else $error("frame flash not started");
  chk_err_flash: assert property (@(posedge mclk_in) disable iff (rst_in)
    chan_in[NCH-1].err_frame && flash_q != 32'h0 |=> red_cnt_q[NCH-1] != 32'h0)
    else $error("error flash not started");
  chk_slow_equal: assert property (@(posedge mclk_in) disable iff (rst_in)
    $changed(slow_ph_q) && $stable(slow_q) |-> slow_cnt_q == 32'h0)
    else $error("slow phase count not restarted");
  chk_run_one: assert property (@(posedge mclk_in) disable iff (rst_in)
    ctrl_q[cli_pkg::CTRL_RUNNING_BIT] && ovr_en_q == 32'h0 |=>
      $onehot({traffic_out, power_indicator_out}))
    else $error("running lights not one at a time");
  chk_override: assert property (@(posedge mclk_in) disable iff (rst_in)
    ovr_en_q[0] |=> power_indicator_out == $past(ovr_val_q[1:0]))
    else $error("override not applied");

endmodule : cli_led_status

`default_nettype wire
